/* logic/ocdc_params.svh */
`ifndef OCDC_PARAMS_SVH
`define OCDC_PARAMS_SVH

// Register byte addresses
`define OCDC_CH2_ADDR 8'h22
`define OCDC_CH3_ADDR 8'h23

// Field positions inside a channel control byte
`define OCDC_RSV_BIT 7
`define OCDC_FMT_MSB 6
`define OCDC_FMT_LSB 5
`define OCDC_SETA_MSB 4
`define OCDC_SETA_LSB 3
`define OCDC_SETB_MSB 2
`define OCDC_SETB_LSB 1

// Reset values
`define OCDC_FMT_RST 2'h1
`define OCDC_SETA_RST 2'h2
`define OCDC_SETB_RST 2'h0
`define OCDC_RSV_RST 1'h1

// Bits kept in non-volatile storage, per channel
`define OCDC_NVM_MASK_CH2 8'hFE
`define OCDC_NVM_MASK_CH3 8'h7E

// Tail current in mA for setting a codes 0..3
`define OCDC_TAIL_MA0 5'h04
`define OCDC_TAIL_MA1 5'h06
`define OCDC_TAIL_MA2 5'h08
`define OCDC_TAIL_MA3_HCSL 5'h10
`define OCDC_TAIL_MA3_AC 5'h08

// Load resistance in ohms for setting b codes 1..3
`define OCDC_LOAD_OHM1 8'h32
`define OCDC_LOAD_OHM2 8'h64
`define OCDC_LOAD_OHM3 8'hC8

`endif

/* logic/ocdc_pkg.sv */
package ocdc_pkg;
    // Output driver format, order matches the field encoding
    typedef enum logic [1:0] {
        OCDC_FMT_OFF,
        OCDC_FMT_AC_DIFF,
        OCDC_FMT_HCSL,
        OCDC_FMT_CMOS
    } ocdc_fmt_t;

    // Single-ended pin state, order matches the field encoding
    typedef enum logic [1:0] {
        OCDC_PIN_OFF_TRI,
        OCDC_PIN_OFF_LOW,
        OCDC_PIN_INVERTED,
        OCDC_PIN_NORMAL
    } ocdc_pin_t;
endpackage

/* logic/ocdc_chan_decode.sv */
`include "ocdc_params.svh"

// Turns one channel's stored fields into driver controls, purely combinational
module ocdc_chan_decode
    import ocdc_pkg::*;
(
    // Stored fields
    input wire logic [1:0] fmt,
    input wire logic [1:0] setting_a,
    input wire logic [1:0] setting_b,
    // Format and differential driver controls
    output logic diff_en,
    output logic hcsl_en,
    output logic cmos_en,
    output logic [4:0] tail_ma,
    output logic [7:0] load_ohm,
    output logic load_off,
    // Single-ended pin controls, positive then negative
    output logic p_pwr,
    output logic p_oe_n,
    output logic p_inv,
    output logic p_low,
    output logic n_pwr,
    output logic n_oe_n,
    output logic n_inv,
    output logic n_low
);
    // Pin decode shared by both pins: {pwr, oe_n, inv, low}
    function automatic logic [3:0] ocdc_pin_decode(input logic on, input logic [1:0] code);
        logic [3:0] r;
        r = 4'b0100;
        if (on) begin
            case (ocdc_pin_t'(code))
                OCDC_PIN_OFF_TRI: r = 4'b0100;
                OCDC_PIN_OFF_LOW: r = 4'b0001;
                OCDC_PIN_INVERTED: r = 4'b1010;
                default: r = 4'b1000;
            endcase
        end
        return r;
    endfunction

    // Format and differential settings
    always_comb begin
        diff_en = 1'b0;
        hcsl_en = 1'b0;
        cmos_en = 1'b0;
        tail_ma = 5'h00;
        load_ohm = 8'h00;
        load_off = 1'b1;
        case (ocdc_fmt_t'(fmt))
            OCDC_FMT_AC_DIFF: diff_en = 1'b1;
            OCDC_FMT_HCSL: begin
                diff_en = 1'b1;
                hcsl_en = 1'b1;
            end
            OCDC_FMT_CMOS: cmos_en = 1'b1;
            default: diff_en = 1'b0;
        endcase
        if (diff_en) begin
            case (setting_a)
                2'h0: tail_ma = `OCDC_TAIL_MA0;
                2'h1: tail_ma = `OCDC_TAIL_MA1;
                2'h2: tail_ma = `OCDC_TAIL_MA2;
                default: tail_ma = hcsl_en ? `OCDC_TAIL_MA3_HCSL : `OCDC_TAIL_MA3_AC;
            endcase
            case (setting_b)
                2'h1: load_ohm = `OCDC_LOAD_OHM1;
                2'h2: load_ohm = `OCDC_LOAD_OHM2;
                2'h3: load_ohm = `OCDC_LOAD_OHM3;
                default: load_ohm = 8'h00;
            endcase
            load_off = (setting_b == 2'h0);
        end
    end

    // Pins only come alive in single-ended format
    always_comb begin
        {p_pwr, p_oe_n, p_inv, p_low} = ocdc_pin_decode(cmos_en, setting_a);
        {n_pwr, n_oe_n, n_inv, n_low} = ocdc_pin_decode(cmos_en, setting_b);
    end
endmodule

/* logic/ocdc_top.sv */
`include "ocdc_params.svh"

module ocdc_top
    import ocdc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Non-volatile image load and store
    input wire logic nvm_load,
    input wire logic [7:0] nvm_ch2_image,
    input wire logic [7:0] nvm_ch3_image,
    output logic [7:0] nvm_ch2_store,
    output logic [7:0] nvm_ch3_store,
    // Channel 2 driver controls
    output logic ch2_diff_en,
    output logic ch2_hcsl_en,
    output logic ch2_cmos_en,
    output logic [4:0] ch2_tail_ma,
    output logic [7:0] ch2_load_ohm,
    output logic ch2_load_off,
    output logic ch2_p_pwr,
    output logic ch2_p_oe_n,
    output logic ch2_p_inv,
    output logic ch2_p_low,
    output logic ch2_n_pwr,
    output logic ch2_n_oe_n,
    output logic ch2_n_inv,
    output logic ch2_n_low,
    // Channel 3 driver controls
    output logic ch3_diff_en,
    output logic ch3_hcsl_en,
    output logic ch3_cmos_en,
    output logic [4:0] ch3_tail_ma,
    output logic [7:0] ch3_load_ohm,
    output logic ch3_load_off,
    output logic ch3_p_pwr,
    output logic ch3_p_oe_n,
    output logic ch3_p_inv,
    output logic ch3_p_low,
    output logic ch3_n_pwr,
    output logic ch3_n_oe_n,
    output logic ch3_n_inv,
    output logic ch3_n_low
);
    // Builds a register byte; bit 0 is always zero
    function automatic logic [7:0] ocdc_pack(input logic rsv, input logic [1:0] fmt,
                                             input logic [1:0] a, input logic [1:0] b);
        return {rsv, fmt, a, b, 1'b0};
    endfunction

    // Stored fields, current and next
    logic [1:0] ch2_fmt_reg, ch2_fmt_next;
    logic [1:0] ch2_drive_setting_a_reg, ch2_drive_setting_a_next;
    logic [1:0] ch2_drive_setting_b_reg, ch2_drive_setting_b_next;
    logic ch2_reserved_bit_reg, ch2_reserved_bit_next;
    logic [1:0] ch3_fmt_reg, ch3_fmt_next;
    logic [1:0] ch3_drive_setting_a_reg, ch3_drive_setting_a_next;
    logic [1:0] ch3_drive_setting_b_reg, ch3_drive_setting_b_next;

    // Bus answer and storage image
    logic [7:0] rdata_reg, rdata_next;
    logic [7:0] ch2_store_reg, ch2_store_next;
    logic [7:0] ch3_store_reg, ch3_store_next;

    // Address hits
    logic hit_ch2;
    logic hit_ch3;

    // Decoded controls, combinational
    logic d2_diff, d2_hcsl, d2_cmos, d2_load_off;
    logic [4:0] d2_tail;
    logic [7:0] d2_load;
    logic d2_p_pwr, d2_p_oe_n, d2_p_inv, d2_p_low;
    logic d2_n_pwr, d2_n_oe_n, d2_n_inv, d2_n_low;
    logic d3_diff, d3_hcsl, d3_cmos, d3_load_off;
    logic [4:0] d3_tail;
    logic [7:0] d3_load;
    logic d3_p_pwr, d3_p_oe_n, d3_p_inv, d3_p_low;
    logic d3_n_pwr, d3_n_oe_n, d3_n_inv, d3_n_low;

    // Address decode
    always_comb begin
        hit_ch2 = 1'b0;
        hit_ch3 = 1'b0;
        if (reg_addr == `OCDC_CH2_ADDR) begin
            hit_ch2 = 1'b1;
        end else if (reg_addr == `OCDC_CH3_ADDR) begin
            hit_ch3 = 1'b1;
        end
    end

    // Field update: storage load first, a bus write in the same cycle wins
    always_comb begin
        ch2_fmt_next = ch2_fmt_reg;
        ch2_drive_setting_a_next = ch2_drive_setting_a_reg;
        ch2_drive_setting_b_next = ch2_drive_setting_b_reg;
        ch2_reserved_bit_next = ch2_reserved_bit_reg;
        ch3_fmt_next = ch3_fmt_reg;
        ch3_drive_setting_a_next = ch3_drive_setting_a_reg;
        ch3_drive_setting_b_next = ch3_drive_setting_b_reg;
        if (nvm_load) begin
            // Only stored bits come back from the image
            ch2_reserved_bit_next = nvm_ch2_image[`OCDC_RSV_BIT];
            ch2_fmt_next = nvm_ch2_image[`OCDC_FMT_MSB:`OCDC_FMT_LSB];
            ch2_drive_setting_a_next = nvm_ch2_image[`OCDC_SETA_MSB:`OCDC_SETA_LSB];
            ch2_drive_setting_b_next = nvm_ch2_image[`OCDC_SETB_MSB:`OCDC_SETB_LSB];
            ch3_fmt_next = nvm_ch3_image[`OCDC_FMT_MSB:`OCDC_FMT_LSB];
            ch3_drive_setting_a_next = nvm_ch3_image[`OCDC_SETA_MSB:`OCDC_SETA_LSB];
            ch3_drive_setting_b_next = nvm_ch3_image[`OCDC_SETB_MSB:`OCDC_SETB_LSB];
        end
        if (reg_wr && hit_ch2) begin
            // Bit 0 has no storage, so its write data is dropped
            ch2_reserved_bit_next = reg_wdata[`OCDC_RSV_BIT];
            ch2_fmt_next = reg_wdata[`OCDC_FMT_MSB:`OCDC_FMT_LSB];
            ch2_drive_setting_a_next = reg_wdata[`OCDC_SETA_MSB:`OCDC_SETA_LSB];
            ch2_drive_setting_b_next = reg_wdata[`OCDC_SETB_MSB:`OCDC_SETB_LSB];
        end else if (reg_wr && hit_ch3) begin
            // Bits 7 and 0 have no storage on this channel
            ch3_fmt_next = reg_wdata[`OCDC_FMT_MSB:`OCDC_FMT_LSB];
            ch3_drive_setting_a_next = reg_wdata[`OCDC_SETA_MSB:`OCDC_SETA_LSB];
            ch3_drive_setting_b_next = reg_wdata[`OCDC_SETB_MSB:`OCDC_SETB_LSB];
        end
    end

    // Read answer and storage image
    always_comb begin
        rdata_next = 8'h00;
        if (reg_rd) begin
            if (hit_ch2) begin
                rdata_next = ocdc_pack(ch2_reserved_bit_reg, ch2_fmt_reg,
                                       ch2_drive_setting_a_reg, ch2_drive_setting_b_reg);
            end else if (hit_ch3) begin
                // Bit 7 reads zero here
                rdata_next = ocdc_pack(1'b0, ch3_fmt_reg,
                                       ch3_drive_setting_a_reg, ch3_drive_setting_b_reg);
            end
        end
        // Mask keeps unstored bits out of the image
        ch2_store_next = `OCDC_NVM_MASK_CH2 & ocdc_pack(ch2_reserved_bit_reg, ch2_fmt_reg,
                         ch2_drive_setting_a_reg, ch2_drive_setting_b_reg);
        ch3_store_next = `OCDC_NVM_MASK_CH3 & ocdc_pack(1'b0, ch3_fmt_reg,
                         ch3_drive_setting_a_reg, ch3_drive_setting_b_reg);
    end

    // Register stage for fields, answer and image
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ch2_fmt_reg <= `OCDC_FMT_RST;
            ch2_drive_setting_a_reg <= `OCDC_SETA_RST;
            ch2_drive_setting_b_reg <= `OCDC_SETB_RST;
            ch2_reserved_bit_reg <= `OCDC_RSV_RST;
            ch3_fmt_reg <= `OCDC_FMT_RST;
            ch3_drive_setting_a_reg <= `OCDC_SETA_RST;
            ch3_drive_setting_b_reg <= `OCDC_SETB_RST;
            rdata_reg <= 8'h00;
            ch2_store_reg <= 8'h00;
            ch3_store_reg <= 8'h00;
        end else begin
            ch2_fmt_reg <= ch2_fmt_next;
            ch2_drive_setting_a_reg <= ch2_drive_setting_a_next;
            ch2_drive_setting_b_reg <= ch2_drive_setting_b_next;
            ch2_reserved_bit_reg <= ch2_reserved_bit_next;
            ch3_fmt_reg <= ch3_fmt_next;
            ch3_drive_setting_a_reg <= ch3_drive_setting_a_next;
            ch3_drive_setting_b_reg <= ch3_drive_setting_b_next;
            rdata_reg <= rdata_next;
            ch2_store_reg <= ch2_store_next;
            ch3_store_reg <= ch3_store_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign nvm_ch2_store = ch2_store_reg;
    assign nvm_ch3_store = ch3_store_reg;

    // Channel 2 decode
    ocdc_chan_decode u_dec2 (
        .fmt(ch2_fmt_reg),
        .setting_a(ch2_drive_setting_a_reg),
        .setting_b(ch2_drive_setting_b_reg),
        .diff_en(d2_diff),
        .hcsl_en(d2_hcsl),
        .cmos_en(d2_cmos),
        .tail_ma(d2_tail),
        .load_ohm(d2_load),
        .load_off(d2_load_off),
        .p_pwr(d2_p_pwr),
        .p_oe_n(d2_p_oe_n),
        .p_inv(d2_p_inv),
        .p_low(d2_p_low),
        .n_pwr(d2_n_pwr),
        .n_oe_n(d2_n_oe_n),
        .n_inv(d2_n_inv),
        .n_low(d2_n_low)
    );

    // Channel 3 decode
    ocdc_chan_decode u_dec3 (
        .fmt(ch3_fmt_reg),
        .setting_a(ch3_drive_setting_a_reg),
        .setting_b(ch3_drive_setting_b_reg),
        .diff_en(d3_diff),
        .hcsl_en(d3_hcsl),
        .cmos_en(d3_cmos),
        .tail_ma(d3_tail),
        .load_ohm(d3_load),
        .load_off(d3_load_off),
        .p_pwr(d3_p_pwr),
        .p_oe_n(d3_p_oe_n),
        .p_inv(d3_p_inv),
        .p_low(d3_p_low),
        .n_pwr(d3_n_pwr),
        .n_oe_n(d3_n_oe_n),
        .n_inv(d3_n_inv),
        .n_low(d3_n_low)
    );

    // Driver controls are retimed so the analogue side sees clean levels;
    // costs one cycle after each field change. Reset parks every driver off.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ch2_diff_en <= 1'b0;
            ch2_hcsl_en <= 1'b0;
            ch2_cmos_en <= 1'b0;
            ch2_tail_ma <= 5'h00;
            ch2_load_ohm <= 8'h00;
            ch2_load_off <= 1'b1;
            ch2_p_pwr <= 1'b0;
            ch2_p_oe_n <= 1'b1;
            ch2_p_inv <= 1'b0;
            ch2_p_low <= 1'b0;
            ch2_n_pwr <= 1'b0;
            ch2_n_oe_n <= 1'b1;
            ch2_n_inv <= 1'b0;
            ch2_n_low <= 1'b0;
            ch3_diff_en <= 1'b0;
            ch3_hcsl_en <= 1'b0;
            ch3_cmos_en <= 1'b0;
            ch3_tail_ma <= 5'h00;
            ch3_load_ohm <= 8'h00;
            ch3_load_off <= 1'b1;
            ch3_p_pwr <= 1'b0;
            ch3_p_oe_n <= 1'b1;
            ch3_p_inv <= 1'b0;
            ch3_p_low <= 1'b0;
            ch3_n_pwr <= 1'b0;
            ch3_n_oe_n <= 1'b1;
            ch3_n_inv <= 1'b0;
            ch3_n_low <= 1'b0;
        end else begin
            ch2_diff_en <= d2_diff;
            ch2_hcsl_en <= d2_hcsl;
            ch2_cmos_en <= d2_cmos;
            ch2_tail_ma <= d2_tail;
            ch2_load_ohm <= d2_load;
            ch2_load_off <= d2_load_off;
            ch2_p_pwr <= d2_p_pwr;
            ch2_p_oe_n <= d2_p_oe_n;
            ch2_p_inv <= d2_p_inv;
            ch2_p_low <= d2_p_low;
            ch2_n_pwr <= d2_n_pwr;
            ch2_n_oe_n <= d2_n_oe_n;
            ch2_n_inv <= d2_n_inv;
            ch2_n_low <= d2_n_low;
            ch3_diff_en <= d3_diff;
            ch3_hcsl_en <= d3_hcsl;
            ch3_cmos_en <= d3_cmos;
            ch3_tail_ma <= d3_tail;
            ch3_load_ohm <= d3_load;
            ch3_load_off <= d3_load_off;
            ch3_p_pwr <= d3_p_pwr;
            ch3_p_oe_n <= d3_p_oe_n;
            ch3_p_inv <= d3_p_inv;
            ch3_p_low <= d3_p_low;
            ch3_n_pwr <= d3_n_pwr;
            ch3_n_oe_n <= d3_n_oe_n;
            ch3_n_inv <= d3_n_inv;
            ch3_n_low <= d3_n_low;
        end
    end
endmodule

/* tb/ocdc_checker.sv */
module ocdc_checker
    import ocdc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Storage side
    input wire logic nvm_load,
    input wire logic [7:0] nvm_ch2_image,
    input wire logic [7:0] nvm_ch2_store,
    // Channel 2 drivers
    input wire logic ch2_hcsl_en,
    input wire logic ch2_cmos_en,
    input wire logic [4:0] ch2_tail_ma,
    input wire logic [7:0] ch2_load_ohm,
    input wire logic ch2_load_off,
    input wire logic ch2_p_pwr,
    input wire logic ch2_p_oe_n,
    input wire logic ch2_p_inv,
    input wire logic ch2_p_low,
    // Channel 3 negative pin
    input wire logic ch3_n_pwr,
    input wire logic ch3_n_oe_n,
    input wire logic ch3_n_inv,
    input wire logic ch3_n_low
);
    timeunit 1ns;
    timeprecision 1ps;
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // Drivers and store lag a write by two edges; a later load cannot reach them sooner
    property p_fmt;
        reg_wr && reg_addr == 8'h22 |-> ##2
        ch2_cmos_en == ($past(reg_wdata[6:5], 2) == 2'h3) &&
        ch2_hcsl_en == ($past(reg_wdata[6:5], 2) == 2'h2);
    endproperty
    a_fmt: assert property (p_fmt) else $error("format decode wrong");
    property p_tail_hcsl;
        reg_wr && reg_addr == 8'h22 && reg_wdata[6:3] == 4'hB |-> ##2 ch2_tail_ma == 5'h10;
    endproperty
    a_tail_hcsl: assert property (p_tail_hcsl) else $error("hcsl tail wrong");
    property p_tail_ac;
        reg_wr && reg_addr == 8'h22 && reg_wdata[6:3] == 4'h7 |-> ##2 ch2_tail_ma == 5'h08;
    endproperty
    a_tail_ac: assert property (p_tail_ac) else $error("ac tail wrong");
    property p_load;
        reg_wr && reg_addr == 8'h22 && reg_wdata[6:5] == 2'h2 && reg_wdata[2:1] == 2'h3
        |-> ##2 ch2_load_ohm == 8'hC8 && !ch2_load_off;
    endproperty
    a_load: assert property (p_load) else $error("load decode wrong");
    property p_ppin;
        reg_wr && reg_addr == 8'h22 && reg_wdata[6:5] == 2'h3 |-> ##2
        ch2_p_oe_n == ($past(reg_wdata[4:3], 2) == 2'h0) &&
        ch2_p_low == ($past(reg_wdata[4:3], 2) == 2'h1) &&
        ch2_p_inv == ($past(reg_wdata[4:3], 2) == 2'h2) && ch2_p_pwr == $past(reg_wdata[4], 2);
    endproperty
    a_ppin: assert property (p_ppin) else $error("positive pin wrong");
    property p_npin;
        reg_wr && reg_addr == 8'h23 && reg_wdata[6:5] == 2'h3 |-> ##2
        ch3_n_oe_n == ($past(reg_wdata[2:1], 2) == 2'h0) &&
        ch3_n_low == ($past(reg_wdata[2:1], 2) == 2'h1) &&
        ch3_n_inv == ($past(reg_wdata[2:1], 2) == 2'h2) && ch3_n_pwr == $past(reg_wdata[2], 2);
    endproperty
    a_npin: assert property (p_npin) else $error("negative pin wrong");
    property p_readback;
        reg_wr && reg_addr == 8'h22 ##1 reg_rd && reg_addr == 8'h22
        |=> reg_rdata == ($past(reg_wdata, 2) & 8'hFE);
    endproperty
    a_readback: assert property (p_readback) else $error("readback wrong");
    property p_store;
        reg_wr && reg_addr == 8'h22 |-> ##2 nvm_ch2_store == ($past(reg_wdata, 2) & 8'hFE);
    endproperty
    a_store: assert property (p_store) else $error("store image wrong");
    property p_image;
        nvm_load && !reg_wr |-> ##2 nvm_ch2_store == ($past(nvm_ch2_image, 2) & 8'hFE);
    endproperty
    a_image: assert property (p_image) else $error("image load wrong");
    property p_unmapped;
        reg_rd && reg_addr != 8'h22 && reg_addr != 8'h23 |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

bind ocdc_top ocdc_checker i_ocdc_checker (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nvm_load(nvm_load),
    .nvm_ch2_image(nvm_ch2_image), .nvm_ch2_store(nvm_ch2_store),
    .ch2_hcsl_en(ch2_hcsl_en), .ch2_cmos_en(ch2_cmos_en), .ch2_tail_ma(ch2_tail_ma),
    .ch2_load_ohm(ch2_load_ohm), .ch2_load_off(ch2_load_off), .ch2_p_pwr(ch2_p_pwr),
    .ch2_p_oe_n(ch2_p_oe_n), .ch2_p_inv(ch2_p_inv), .ch2_p_low(ch2_p_low),
    .ch3_n_pwr(ch3_n_pwr), .ch3_n_oe_n(ch3_n_oe_n), .ch3_n_inv(ch3_n_inv),
    .ch3_n_low(ch3_n_low)
);

/* tb/ocdc_rx_model.sv */
// Receiver on one single-ended output pin
module ocdc_rx_model (
    // Reference clock standing in for the divided clock
    input wire logic clk,
    // Pin controls from the driver
    input wire logic pwr,
    input wire logic oe_n,
    input wire logic inv,
    input wire logic low,
    // Level seen at the receiver
    output logic pin_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic float_reg = 1'b0;
    // No pull on the pin, so a released pin wanders instead of holding
    always @(posedge clk) begin
        float_reg <= ~float_reg;
    end
    // Driven pin is low when parked, else the clock with chosen polarity
    always_comb begin
        if (oe_n) begin
            pin_seen = float_reg;
        end else if (low || !pwr) begin
            pin_seen = 1'b0;
        end else begin
            pin_seen = clk ^ inv;
        end
    end
endmodule

/* tb/tb.sv */
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); end end

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    int mismatches = 0;
    int samples_checked = 0;
    // Inputs, all defined at time zero
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic nvm_load = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] nvm_ch2_image = 8'h00;
    logic [7:0] nvm_ch3_image = 8'h00;
    logic [7:0] d;
    // Outputs
    logic [7:0] reg_rdata, nvm_ch2_store, nvm_ch3_store, ch2_load_ohm, ch3_load_ohm;
    logic [4:0] ch2_tail_ma, ch3_tail_ma;
    logic ch2_diff_en, ch2_hcsl_en, ch2_cmos_en, ch2_load_off, pin_seen;
    logic ch3_diff_en, ch3_hcsl_en, ch3_cmos_en, ch3_load_off;
    logic ch2_p_pwr, ch2_p_oe_n, ch2_p_inv, ch2_p_low, ch2_n_pwr, ch2_n_oe_n, ch2_n_inv;
    logic ch3_p_pwr, ch3_p_oe_n, ch3_p_inv, ch3_p_low, ch3_n_pwr, ch3_n_oe_n, ch3_n_inv;
    logic ch2_n_low, ch3_n_low;
    // Each channel's drivers packed for one compare
    wire [24:0] drv2 = {ch2_diff_en, ch2_hcsl_en, ch2_cmos_en, ch2_tail_ma, ch2_load_ohm,
        ch2_load_off, ch2_p_pwr, ch2_p_oe_n, ch2_p_inv, ch2_p_low,
        ch2_n_pwr, ch2_n_oe_n, ch2_n_inv, ch2_n_low};
    wire [24:0] drv3 = {ch3_diff_en, ch3_hcsl_en, ch3_cmos_en, ch3_tail_ma, ch3_load_ohm,
        ch3_load_off, ch3_p_pwr, ch3_p_oe_n, ch3_p_inv, ch3_p_low,
        ch3_n_pwr, ch3_n_oe_n, ch3_n_inv, ch3_n_low};

    ocdc_top i_ocdc_top (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nvm_load(nvm_load),
        .nvm_ch2_image(nvm_ch2_image), .nvm_ch3_image(nvm_ch3_image),
        .nvm_ch2_store(nvm_ch2_store), .nvm_ch3_store(nvm_ch3_store),
        .ch2_diff_en(ch2_diff_en), .ch2_hcsl_en(ch2_hcsl_en), .ch2_cmos_en(ch2_cmos_en),
        .ch2_tail_ma(ch2_tail_ma), .ch2_load_ohm(ch2_load_ohm), .ch2_load_off(ch2_load_off),
        .ch2_p_pwr(ch2_p_pwr), .ch2_p_oe_n(ch2_p_oe_n), .ch2_p_inv(ch2_p_inv),
        .ch2_p_low(ch2_p_low), .ch2_n_pwr(ch2_n_pwr), .ch2_n_oe_n(ch2_n_oe_n),
        .ch2_n_inv(ch2_n_inv), .ch2_n_low(ch2_n_low),
        .ch3_diff_en(ch3_diff_en), .ch3_hcsl_en(ch3_hcsl_en), .ch3_cmos_en(ch3_cmos_en),
        .ch3_tail_ma(ch3_tail_ma), .ch3_load_ohm(ch3_load_ohm), .ch3_load_off(ch3_load_off),
        .ch3_p_pwr(ch3_p_pwr), .ch3_p_oe_n(ch3_p_oe_n), .ch3_p_inv(ch3_p_inv),
        .ch3_p_low(ch3_p_low), .ch3_n_pwr(ch3_n_pwr), .ch3_n_oe_n(ch3_n_oe_n),
        .ch3_n_inv(ch3_n_inv), .ch3_n_low(ch3_n_low)
    );
    // Receiver on the channel 2 positive pin
    ocdc_rx_model i_ocdc_rx_model (.clk(clk), .pwr(ch2_p_pwr), .oe_n(ch2_p_oe_n),
        .inv(ch2_p_inv), .low(ch2_p_low), .pin_seen(pin_seen));

    // 200 MHz clock
    initial begin
        forever #2.5 clk = ~clk;
    end

    // Pin code to {pwr, oe_n, inv, low}; parked unless single-ended
    function automatic logic [3:0] pin_of(logic [1:0] c, logic on);
        if (!on || c == 2'h0) return 4'h4;
        return (c == 2'h1) ? 4'h1 : (c == 2'h2) ? 4'hA : 4'h8;
    endfunction
    // Expected driver vector from format and both settings
    function automatic logic [24:0] drv_of(logic [1:0] f, logic [1:0] a, logic [1:0] b);
        logic dif;
        logic [4:0] t;
        logic [7:0] r;
        dif = (f == 2'h1) || (f == 2'h2);
        t = (a == 2'h0) ? 5'h04 : (a == 2'h1) ? 5'h06 : (a == 2'h3 && f == 2'h2) ? 5'h10 : 5'h08;
        r = (b == 2'h1) ? 8'h32 : (b == 2'h2) ? 8'h64 : (b == 2'h3) ? 8'hC8 : 8'h00;
        return {dif, f == 2'h2, f == 2'h3, dif ? t : 5'h00, dif ? r : 8'h00,
            !dif || b == 2'h0, pin_of(a, f == 2'h3), pin_of(b, f == 2'h3)};
    endfunction

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // One-cycle read strobe, data looked at in the following cycle only
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK("rdata", e, reg_rdata)
    endtask
    // Counts, verdict, end of run
    task automatic stop_test;
        $display("compares %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Whole run is near 690 cycles, so this leaves a wide margin
    initial begin
        #50us;
        mismatches++;
        stop_test();
    end

    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        rd(8'h22, 8'hB0);
        rd(8'h23, 8'h30);
        `CHK("drv2", drv_of(2'h1, 2'h2, 2'h0), drv2)
        // Every format and setting on both channels; bit 0 and channel 3 bit 7 written high
        for (int c = 0; c < 2; c++) begin
            for (int v = 0; v < 64; v++) begin
                d = {c[0], v[5:0], 1'b1};
                wr(8'h22 + c[7:0], d);
                @(posedge clk);
                #1;
                `CHK("drv", drv_of(v[5:4], v[3:2], v[1:0]), c ? drv3 : drv2)
                `CHK("store", d & (c ? 8'h7E : 8'hFE), c ? nvm_ch3_store : nvm_ch2_store)
                if (c == 0 && v[5:4] == 2'h3 && v[3:2] != 2'h0) begin
                    `CHK("pin", v[3:2] == 2'h3, pin_seen)
                end
                rd(8'h22 + c[7:0], d & (c ? 8'h7E : 8'hFE));
            end
        end
        wr(8'h22, 8'hB4);
        rd(8'h22, 8'hB4);
        // Unmapped places take nothing and read zero
        wr(8'h24, 8'hFF);
        rd(8'h24, 8'h00);
        rd(8'h21, 8'h00);
        rd(8'h22, 8'hB4);
        // Write then read with no gap; bit 0 written high must read back low
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= 8'h22;
        reg_wdata <= 8'h1B;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK("b2b", 8'h1A, reg_rdata)
        // Storage load, then a write racing a load
        @(posedge clk);
        nvm_ch2_image <= 8'h7F;
        nvm_ch3_image <= 8'hFF;
        nvm_load <= 1'b1;
        @(posedge clk);
        nvm_load <= 1'b0;
        @(posedge clk);
        #1;
        `CHK("store2", 8'h7E, nvm_ch2_store)
        `CHK("store3", 8'h7E, nvm_ch3_store)
        rd(8'h23, 8'h7E);
        @(posedge clk);
        nvm_ch3_image <= 8'hB7;
        nvm_load <= 1'b1;
        reg_wr <= 1'b1;
        reg_addr <= 8'h22;
        reg_wdata <= 8'h02;
        @(posedge clk);
        nvm_load <= 1'b0;
        reg_wr <= 1'b0;
        rd(8'h22, 8'h02);
        rd(8'h23, 8'h36);
        // Second reset in mid-run restores defaults
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(8'h22, 8'hB0);
        rd(8'h23, 8'h30);
        stop_test();
    end
endmodule
